// [rtl/pdmc_consts.vh]
// Register offsets, field positions and reset values for the microphone capture block.
// Assumes a 32-bit classic Wishbone slave with word-aligned byte addresses.
`ifndef PDMC_CONSTS_VH
`define PDMC_CONSTS_VH
`define PDMC_A_START      12'h000
`define PDMC_A_STOP       12'h004
`define PDMC_A_SUB_START  12'h080
`define PDMC_A_SUB_STOP   12'h084
`define PDMC_A_EV_BEGUN   12'h100
`define PDMC_A_EV_HALTED  12'h104
`define PDMC_A_EV_FULL    12'h108
`define PDMC_A_PUB_BEGUN  12'h180
`define PDMC_A_PUB_HALTED 12'h184
`define PDMC_A_PUB_FULL   12'h188
`define PDMC_A_INTERRUPT_ENABLE_MASK      12'h300
`define PDMC_A_INTERRUPT_ENABLE_SET   12'h304
`define PDMC_A_INTERRUPT_ENABLE_CLEAR   12'h308
`define PDMC_A_ENABLE     12'h500
`define PDMC_A_CLKCTRL    12'h504
`define PDMC_A_MODE       12'h508
`define PDMC_A_LEFT_OUTPUT_GAIN      12'h518
`define PDMC_A_RIGHT_OUTPUT_GAIN      12'h51C
`define PDMC_A_RATIO      12'h520
`define PDMC_A_PSEL_CLK   12'h540
`define PDMC_A_PSEL_DIN   12'h544
`define PDMC_A_PTR        12'h560
`define PDMC_A_MAXCNT     12'h564
`define PDMC_CLKCTRL_RST  32'h08400000
`define PDMC_GAIN_RST     7'h28
`define PDMC_PSEL_RST     32'hFFFFFFFF
`define PDMC_PSEL_CONN    31
`define PDMC_SUB_EN       31
`define PDMC_CHANNEL_INDEX_W      4
`define PDMC_MODE_OP      0
`define PDMC_MODE_EDGE    1
`define PDMC_IE_BEGUN     0
`define PDMC_IE_HALTED    1
`define PDMC_IE_FULL      2
`define PDMC_RATIO64      7'd64
`define PDMC_RATIO80      7'd80
`define PDMC_HALF_DIV     5'd2
`define PDMC_FRAC_SHIFT   6
`endif

// [rtl/pdmc_top.v]
// Microphone bit clock generator, two-phase data sampler, decimator and DMA writer.
// Assumes one pin bank, a memory master port with ack handshake, and task channels from the interconnect.
`include "pdmc_consts.vh"

// Notes on behaviour
// - Stereo word: right high half, left low
// - Mono word: earlier low half, later high
// - Samples stored little-endian in memory
// - Count in samples, ceil(count/2) words
// - Pointer double-buffered, latched at buffer start
// - Buffer full raises full event
// - Refill continues at latched pointer, begun event
// - Pin selections apply only while enabled
// - Disconnected selection leaves signal unconnected
// - Start and stop are write-one triggers
// - Subscriptions trigger tasks from selected channel
// - Last sample after stop raises full
// - Stop waits for the next word write to be acked, then halted event
// - Left on falling edge by default, swappable
// - Samples at clock over 64 or 80
module pdmc_top #(
	parameter NPINS = 32,
	parameter PW    = 5
) (
	input  wire              clk_i,
	input  wire              rst_i,
	input  wire              wb_cyc_i,
	input  wire              wb_stb_i,
	input  wire              wb_we_i,
	input  wire [11:0]       wb_adr_i,
	input  wire [3:0]        wb_sel_i,
	input  wire [31:0]       wb_dat_i,
	output reg  [31:0]       wb_dat_o,
	output reg               wb_ack_o,
	input  wire [15:0]       chan_i,
	output wire [15:0]       chan_o,
	output wire              irq_o,
	input  wire [NPINS-1:0]  pin_in_i,
	output wire [NPINS-1:0]  pin_out_o,
	output wire [NPINS-1:0]  pin_oe_o,
	output wire [NPINS-1:0]  pin_own_o,
	output reg  [31:0]       mem_adr_o,
	output reg  [31:0]       mem_dat_o,
	output wire              mem_req_o,
	input  wire              mem_ack_i
);
	// ****************************************
	// Registers
	// ****************************************
	reg        en_q, op_q, edge_q;
	reg [31:0] sub_start_q, sub_stop_q, pub_b_q, pub_h_q, pub_f_q;
	reg [31:0] clkctrl_q, psel_clk_q, psel_din_q, ptr_q, maxcnt_q;
	reg [6:0]  left_output_gain_q, right_output_gain_q;
	reg        ratio_q;
	reg [2:0]  ev_q, ie_q;
	wire       wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
	wire       rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
	wire [2:0] ev_set;
	wire start_trig = (wr & wb_adr_i == `PDMC_A_START & wb_dat_i[0])
		| (sub_start_q[`PDMC_SUB_EN] & chan_i[sub_start_q[`PDMC_CHANNEL_INDEX_W-1:0]]);
	wire stop_trig = (wr & wb_adr_i == `PDMC_A_STOP & wb_dat_i[0])
		| (sub_stop_q[`PDMC_SUB_EN] & chan_i[sub_stop_q[`PDMC_CHANNEL_INDEX_W-1:0]]);
	assign irq_o = |(ev_q & ie_q);
	genvar g;
	generate
		for (g = 0; g < 16; g = g + 1) begin : g_pub
			assign chan_o[g] = (pub_b_q[`PDMC_SUB_EN] & pub_b_q[`PDMC_CHANNEL_INDEX_W-1:0] == g & ev_set[`PDMC_IE_BEGUN])
				| (pub_h_q[`PDMC_SUB_EN] & pub_h_q[`PDMC_CHANNEL_INDEX_W-1:0] == g & ev_set[`PDMC_IE_HALTED])
				| (pub_f_q[`PDMC_SUB_EN] & pub_f_q[`PDMC_CHANNEL_INDEX_W-1:0] == g & ev_set[`PDMC_IE_FULL]);
		end
	endgenerate

	always @(posedge clk_i) begin
		wb_ack_o <= (wr | rd);
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			en_q <= 1'b0; op_q <= 1'b0; edge_q <= 1'b0; ratio_q <= 1'b0;
			sub_start_q <= 32'h0; sub_stop_q <= 32'h0;
			pub_b_q <= 32'h0; pub_h_q <= 32'h0; pub_f_q <= 32'h0;
			clkctrl_q <= `PDMC_CLKCTRL_RST;
			psel_clk_q <= `PDMC_PSEL_RST; psel_din_q <= `PDMC_PSEL_RST;
			ptr_q <= 32'h0; maxcnt_q <= 32'h0;
			left_output_gain_q <= `PDMC_GAIN_RST; right_output_gain_q <= `PDMC_GAIN_RST;
			ev_q <= 3'b000; ie_q <= 3'b000;
		end else begin
			if (wr) begin
				case (wb_adr_i)
				`PDMC_A_SUB_START:  sub_start_q <= wb_dat_i;
				`PDMC_A_SUB_STOP:   sub_stop_q <= wb_dat_i;
				`PDMC_A_PUB_BEGUN:  pub_b_q <= wb_dat_i;
				`PDMC_A_PUB_HALTED: pub_h_q <= wb_dat_i;
				`PDMC_A_PUB_FULL:   pub_f_q <= wb_dat_i;
				`PDMC_A_INTERRUPT_ENABLE_MASK:      ie_q <= wb_dat_i[2:0];
				`PDMC_A_INTERRUPT_ENABLE_SET:   ie_q <= ie_q | wb_dat_i[2:0];
				`PDMC_A_INTERRUPT_ENABLE_CLEAR:   ie_q <= ie_q & ~wb_dat_i[2:0];
				`PDMC_A_ENABLE:     en_q <= wb_dat_i[0];
				`PDMC_A_CLKCTRL:    clkctrl_q <= wb_dat_i;
				`PDMC_A_MODE: begin
					op_q <= wb_dat_i[`PDMC_MODE_OP];
					edge_q <= wb_dat_i[`PDMC_MODE_EDGE];
				end
				`PDMC_A_LEFT_OUTPUT_GAIN:      left_output_gain_q <= wb_dat_i[6:0];
				`PDMC_A_RIGHT_OUTPUT_GAIN:      right_output_gain_q <= wb_dat_i[6:0];
				`PDMC_A_RATIO:      ratio_q <= wb_dat_i[0];
				`PDMC_A_PSEL_CLK:   psel_clk_q <= wb_dat_i;
				`PDMC_A_PSEL_DIN:   psel_din_q <= wb_dat_i;
				`PDMC_A_PTR:        ptr_q <= wb_dat_i;
				`PDMC_A_MAXCNT:     maxcnt_q <= wb_dat_i;
				default: ;
				endcase
			end
			// Hardware set beats a software clear in the same cycle
			ev_q[0] <= ev_set[0] | (ev_q[0] & ~(wr & wb_adr_i == `PDMC_A_EV_BEGUN & ~wb_dat_i[0]));
			ev_q[1] <= ev_set[1] | (ev_q[1] & ~(wr & wb_adr_i == `PDMC_A_EV_HALTED & ~wb_dat_i[0]));
			ev_q[2] <= ev_set[2] | (ev_q[2] & ~(wr & wb_adr_i == `PDMC_A_EV_FULL & ~wb_dat_i[0]));
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0;
		end else begin
			case (wb_adr_i)
			`PDMC_A_SUB_START:  wb_dat_o <= sub_start_q;
			`PDMC_A_SUB_STOP:   wb_dat_o <= sub_stop_q;
			`PDMC_A_EV_BEGUN:   wb_dat_o <= {31'h0, ev_q[0]};
			`PDMC_A_EV_HALTED:  wb_dat_o <= {31'h0, ev_q[1]};
			`PDMC_A_EV_FULL:    wb_dat_o <= {31'h0, ev_q[2]};
			`PDMC_A_PUB_BEGUN:  wb_dat_o <= pub_b_q;
			`PDMC_A_PUB_HALTED: wb_dat_o <= pub_h_q;
			`PDMC_A_PUB_FULL:   wb_dat_o <= pub_f_q;
			`PDMC_A_INTERRUPT_ENABLE_MASK, `PDMC_A_INTERRUPT_ENABLE_SET, `PDMC_A_INTERRUPT_ENABLE_CLEAR: wb_dat_o <= {29'h0, ie_q};
			`PDMC_A_ENABLE:     wb_dat_o <= {31'h0, en_q};
			`PDMC_A_CLKCTRL:    wb_dat_o <= clkctrl_q;
			`PDMC_A_MODE:       wb_dat_o <= {30'h0, edge_q, op_q};
			`PDMC_A_LEFT_OUTPUT_GAIN:      wb_dat_o <= {25'h0, left_output_gain_q};
			`PDMC_A_RIGHT_OUTPUT_GAIN:      wb_dat_o <= {25'h0, right_output_gain_q};
			`PDMC_A_RATIO:      wb_dat_o <= {31'h0, ratio_q};
			`PDMC_A_PSEL_CLK:   wb_dat_o <= psel_clk_q;
			`PDMC_A_PSEL_DIN:   wb_dat_o <= psel_din_q;
			`PDMC_A_PTR:        wb_dat_o <= ptr_q;
			`PDMC_A_MAXCNT:     wb_dat_o <= maxcnt_q;
			default:            wb_dat_o <= 32'h0;
			endcase
		end
	end

	// ****************************************
	// Pins and bit clock
	// ****************************************
	wire clk_conn = en_q & ~psel_clk_q[`PDMC_PSEL_CONN];
	wire din_conn = en_q & ~psel_din_q[`PDMC_PSEL_CONN];
	wire [PW-1:0] clk_pin = psel_clk_q[PW-1:0];
	wire [PW-1:0] din_pin = psel_din_q[PW-1:0];
	reg  mclk_q;
	reg  running_q;
	assign pin_own_o = ({{(NPINS-1){1'b0}}, clk_conn} << clk_pin) | ({{(NPINS-1){1'b0}}, din_conn} << din_pin);
	assign pin_oe_o  = {{(NPINS-1){1'b0}}, clk_conn} << clk_pin;
	assign pin_out_o = {{(NPINS-1){1'b0}}, clk_conn & mclk_q} << clk_pin;

	// Divider: 32-bit phase accumulator stepped by clkctrl_q; its top bit, registered, is the bit clock
	reg [31:0] acc_q;
	reg        m1_q, m2_q, m2_d1_q;
	always @(posedge clk_i) begin
		if (rst_i | ~running_q) begin
			acc_q <= 32'h0;
			mclk_q <= 1'b0;
		end else begin
			acc_q <= acc_q + clkctrl_q;
			mclk_q <= acc_q[31];
		end
	end
	// Data pin through two flops before use
	always @(posedge clk_i) begin
		if (rst_i) begin
			m1_q <= 1'b0; m2_q <= 1'b0; m2_d1_q <= 1'b0;
		end else begin
			m1_q <= din_conn & pin_in_i[din_pin];
			m2_q <= m1_q;
			m2_d1_q <= mclk_q;
		end
	end
	wire rise = mclk_q & ~m2_d1_q;
	wire fall = ~mclk_q & m2_d1_q;
	wire l_stb = edge_q ? rise : fall;
	wire r_stb = edge_q ? fall : rise;

	// ****************************************
	// Decimator: boxcar count of ones over one output period
	// ****************************************
	// Plain integrator; coefficient shaping and gain are not modelled
	reg [6:0] bits_q;
	reg [6:0] lsum_q, rsum_q;
	reg [15:0] lpcm_q, rpcm_q;
	reg        pcm_v_q;
	wire [6:0] ratio_n = ratio_q ? `PDMC_RATIO80 : `PDMC_RATIO64;
	// Include the bit that lands on the frame boundary, else each frame loses one
	wire [6:0] lsum_n  = lsum_q + {6'h0, l_stb & m2_q};
	wire [6:0] rsum_n  = rsum_q + {6'h0, r_stb & m2_q};
	always @(posedge clk_i) begin
		pcm_v_q <= 1'b0;
		if (rst_i | ~running_q) begin
			bits_q <= 7'h0; lsum_q <= 7'h0; rsum_q <= 7'h0;
			lpcm_q <= 16'h0; rpcm_q <= 16'h0; pcm_v_q <= 1'b0;
		end else begin
			lsum_q <= lsum_n;
			rsum_q <= rsum_n;
			if (rise) begin
				if (bits_q == ratio_n - 7'd1) begin
					bits_q <= 7'h0;
					lpcm_q <= {lsum_n, 9'h0} - {ratio_n, 8'h0};
					rpcm_q <= {rsum_n, 9'h0} - {ratio_n, 8'h0};
					lsum_q <= 7'h0; rsum_q <= 7'h0;
					pcm_v_q <= 1'b1;
				end else begin
					bits_q <= bits_q + 7'd1;
				end
			end
		end
	end

	// ****************************************
	// DMA writer
	// ****************************************
	localparam S_IDLE = 2'd0, S_RUN = 2'd1, S_WR = 2'd2;
	reg [1:0]  st_q;
	reg [31:0] base_q, cnt_q, words_q;
	reg        stop_q, half_q, begun_q, full_q, halted_q;
	reg [15:0] held_q;
	wire [31:0] nwords = (maxcnt_q + 32'd1) >> 1;
	assign mem_req_o = (st_q == S_WR);
	assign ev_set = {full_q, halted_q, begun_q};
	always @(posedge clk_i) begin
		begun_q <= 1'b0; full_q <= 1'b0; halted_q <= 1'b0;
		if (rst_i) begin
			st_q <= S_IDLE; running_q <= 1'b0; stop_q <= 1'b0; half_q <= 1'b0;
			base_q <= 32'h0; cnt_q <= 32'h0; words_q <= 32'h0; held_q <= 16'h0;
			mem_adr_o <= 32'h0; mem_dat_o <= 32'h0;
		end else begin
			if (stop_trig & running_q) stop_q <= 1'b1;
			case (st_q)
			S_IDLE: if (start_trig & en_q) begin
				base_q <= ptr_q;
				cnt_q <= 32'h0; words_q <= nwords; half_q <= 1'b0; stop_q <= 1'b0;
				running_q <= 1'b1; begun_q <= 1'b1; st_q <= S_RUN;
			end
			S_RUN: if (~en_q) begin
				running_q <= 1'b0; halted_q <= 1'b1; st_q <= S_IDLE;
			end else if (pcm_v_q) begin
				if (~op_q) begin
					mem_dat_o <= {rpcm_q, lpcm_q};
					st_q <= S_WR;
				end else if (half_q) begin
					mem_dat_o <= {lpcm_q, held_q};
					half_q <= 1'b0; st_q <= S_WR;
				end else begin
					held_q <= lpcm_q; half_q <= 1'b1;
				end
				mem_adr_o <= base_q + {cnt_q[29:0], 2'b00};
			end
			S_WR: if (mem_ack_i) begin
				if (cnt_q + 32'd1 >= words_q | stop_q) begin
					full_q <= 1'b1;
					if (stop_q) begin
						running_q <= 1'b0; halted_q <= 1'b1; st_q <= S_IDLE;
					end else begin
						base_q <= ptr_q; cnt_q <= 32'h0; words_q <= nwords;
						begun_q <= 1'b1; st_q <= S_RUN;
					end
				end else begin
					cnt_q <= cnt_q + 32'd1; st_q <= S_RUN;
				end
			end
			default: st_q <= S_IDLE;
			endcase
		end
	end
endmodule

// [tb/pdmc_assertions.sv]
// Checker for the microphone capture block, bound to pdmc_top.
// Assumes it sees only the top module's ports.
module pdmc_assertions #(parameter NPINS = 32) (
	input logic             clk_i,
	input logic             rst_i,
	input logic             wb_cyc_i,
	input logic             wb_stb_i,
	input logic             wb_we_i,
	input logic [11:0]      wb_adr_i,
	input logic [31:0]      wb_dat_i,
	input logic [31:0]      wb_dat_o,
	input logic             wb_ack_o,
	input logic             irq_o,
	input logic [NPINS-1:0] pin_oe_o,
	input logic [NPINS-1:0] pin_own_o,
	input logic [31:0]      mem_adr_o,
	input logic             mem_req_o,
	input logic             mem_ack_i
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****
	// Properties
	// ****
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
	sequence s_ack1; wb_ack_o ##1 !wb_ack_o; endsequence
	property p_ack_lat; s_req |=> s_ack1; endproperty
	a_ack_lat: assert property (p_ack_lat) else $error("ack late or long");
	property p_idle; !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o; endproperty
	a_idle: assert property (p_idle) else $error("ack without request");
	property p_wo; wb_ack_o && !wb_we_i && (wb_adr_i[11:3] == 9'h000 || wb_adr_i[11:9] == 3'h3) |-> wb_dat_o == 32'h0; endproperty
	a_wo: assert property (p_wo) else $error("trigger or hole read nonzero");
	property p_hold; mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_adr_o); endproperty
	a_hold: assert property (p_hold) else $error("memory request dropped");
	property p_drop; mem_ack_i |=> !mem_req_o; endproperty
	a_drop: assert property (p_drop) else $error("word written twice");
	property p_own; (pin_oe_o & ~pin_own_o) == '0; endproperty
	a_own: assert property (p_own) else $error("drives unowned pin");
	property p_oe1; $onehot0(pin_oe_o); endproperty
	a_oe1: assert property (p_oe1) else $error("more than clock pin driven");
	property p_irq; wb_ack_o && wb_we_i && wb_adr_i == 12'h308 && wb_dat_i[2:0] == 3'h7 |=> !irq_o; endproperty
	a_irq: assert property (p_irq) else $error("irq after mask clear");
endmodule
bind pdmc_top pdmc_assertions #(.NPINS(NPINS)) u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
	.wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o, .pin_oe_o, .pin_own_o, .mem_adr_o, .mem_req_o, .mem_ack_i);

// [tb/pdmc_mic.sv]
// Pair of microphones sharing one data line.
// Assumes the clock line stands low when not driven.
module pdmc_mic #(parameter logic L_BIT = 1'b1, parameter logic R_BIT = 1'b0) (
	input  logic clk_line_i,
	output logic din_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// Constant streams so each boxcar sum is exact
	assign din_o = clk_line_i ? L_BIT : R_BIT;
endmodule

// [tb/pdmc_top_tb.sv]
// Bench for the capture block: bus tasks, memory responder, scenarios.
// Assumes clock on pin 3 and data on pin 4.
`include "pdmc_consts.vh"
module pdmc_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_i = 0, rst_i = 1, cyc_q = 0, stb_q = 0, we_q = 0, mack_q = 0, pub_seen = 0;
	logic        din, clk_line, wb_ack_o, irq_o, mem_req_o;
	logic [11:0] adr_q = 0;
	logic [15:0] chan_q = 0, chan_o;
	logic [31:0] dat_q = 0, wb_dat_o, mem_adr_o, mem_dat_o, pin_out_o, pin_oe_o, pin_own_o, qa[$], qd[$];
	int          err_count = 0, checked = 0, mwait = 0;
	always #20 clk_i = ~clk_i;
	// Gpio holds the clock pin low while unowned
	assign clk_line = pin_oe_o[3] ? pin_out_o[3] : 1'b0;
	pdmc_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc_q), .wb_stb_i(stb_q), .wb_we_i(we_q), .wb_adr_i(adr_q),
		.wb_sel_i(4'hF), .wb_dat_i(dat_q), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .chan_i(chan_q), .chan_o(chan_o),
		.irq_o(irq_o), .pin_in_i({27'h0, din, clk_line, 3'h0}), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o),
		.pin_own_o(pin_own_o), .mem_adr_o(mem_adr_o), .mem_dat_o(mem_dat_o), .mem_req_o(mem_req_o), .mem_ack_i(mack_q));
	pdmc_mic mic (.clk_line_i(clk_line), .din_o(din));
	// ****
	// Memory side, stalls after the first word
	// ****
	always @(posedge clk_i) begin
		mack_q <= 1'b0;
		if (chan_o[2] === 1'b1) pub_seen <= 1'b1;
		if (mem_req_o && mack_q) begin
			qa.push_back(mem_adr_o);
			qd.push_back(mem_dat_o);
		end else if (mem_req_o) begin
			if (mwait == 0) begin
				mack_q <= 1'b1;
				mwait <= 3;
			end else mwait <= mwait - 1;
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task bus(input logic we, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge clk_i);
		{cyc_q, stb_q, we_q, adr_q, dat_q} <= {2'b11, we, a, d};
		@(posedge clk_i);
		for (n = 0; n < 50 && wb_ack_o !== 1'b1; n++) @(posedge clk_i);
		q = wb_dat_o;
		{cyc_q, stb_q} <= 2'b00;
		if (n == 50) err_count++;
		@(negedge clk_i);
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask
	task wflag(input logic [11:0] a);
		logic [31:0] q;
		int i;
		q = 32'h0;
		for (i = 0; i < 4000 && q[0] !== 1'b1; i++) bus(1'b0, a, 32'h0, q);
		chk(q, 32'h1);
	endtask
	task wq(input int k);
		for (int i = 0; i < 20000 && qa.size() < k; i++) @(posedge clk_i);
	endtask
	// ****
	// Scenarios
	// ****
	task t_regs;
		rd(`PDMC_A_PSEL_CLK, `PDMC_PSEL_RST);
		rd(`PDMC_A_CLKCTRL, `PDMC_CLKCTRL_RST);
		rd(`PDMC_A_START, 32'h0);
		wr(12'h7F0, 32'h1234ABCD);
		rd(12'h7F0, 32'h0);
		wr(`PDMC_A_PTR, 32'h100);
		rd(`PDMC_A_PTR, 32'h100);
		chk(pin_own_o, 32'h0);
		$display("regs done");
	endtask
	task t_stereo;
		wr(`PDMC_A_CLKCTRL, 32'h20000000);
		wr(`PDMC_A_PSEL_CLK, 32'h3);
		wr(`PDMC_A_ENABLE, 32'h1);
		chk(pin_own_o, 32'h8);
		wr(`PDMC_A_PSEL_DIN, 32'h4);
		chk(pin_own_o, 32'h18);
		wr(`PDMC_A_MAXCNT, 32'h4);
		wr(`PDMC_A_PUB_BEGUN, 32'h80000002);
		wr(`PDMC_A_SUB_STOP, 32'h80000005);
		wr(`PDMC_A_INTERRUPT_ENABLE_SET, 32'h1);
		wr(`PDMC_A_START, 32'h1);
		wflag(`PDMC_A_EV_BEGUN);
		chk(irq_o, 32'h1);
		chk(pub_seen, 32'h1);
		wr(`PDMC_A_PTR, 32'h200);
		wr(`PDMC_A_INTERRUPT_ENABLE_CLEAR, 32'h7);
		chk(irq_o, 32'h0);
		// First word holds filter start-up; only its address is judged
		wq(4);
		chk(qa[0], 32'h100);
		chk(qa[3], 32'h204);
		chk(qa[2], 32'h200);
		chk(qd[1], 32'hC0004000);
		chk(qd[3], 32'hC0004000);
		rd(`PDMC_A_EV_FULL, 32'h1);
		wr(`PDMC_A_EV_FULL, 32'h0);
		@(posedge clk_i);
		chan_q <= 16'h0020;
		@(posedge clk_i);
		chan_q <= 16'h0000;
		wflag(`PDMC_A_EV_HALTED);
		chk(mem_req_o, 32'h0);
		rd(`PDMC_A_EV_FULL, 32'h1);
		$display("stereo done");
	endtask
	task t_mono;
		qa.delete();
		qd.delete();
		wr(`PDMC_A_EV_HALTED, 32'h0);
		wr(`PDMC_A_MODE, 32'h3);
		wr(`PDMC_A_PTR, 32'h300);
		wr(`PDMC_A_MAXCNT, 32'h3);
		wr(`PDMC_A_START, 32'h1);
		wq(4);
		chk(qa[1], 32'h304);
		chk(qa[2], 32'h300);
		chk(qd[2], 32'hC000C000);
		wr(`PDMC_A_STOP, 32'h1);
		wflag(`PDMC_A_EV_HALTED);
		wr(`PDMC_A_ENABLE, 32'h0);
		chk(pin_own_o, 32'h0);
		$display("mono done");
	endtask
	task final_report;
		$display("checked %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs;
		t_stereo;
		t_mono;
		final_report;
	end
	initial begin
		repeat (60000) @(posedge clk_i);
		err_count++;
		$display("BAD %0t timeout", $time);
		final_report;
	end
endmodule
